/* rtl/rtcw_pkg.sv */
// constants, field layout and types of the clock window access block
// assumes a 16-bit register port clocked by mclk at 40 MHz
// Notes on behaviour
// [RULE1] timer window pair chosen by pointer
// [RULE2] alarm window pair chosen by alarm pointer
// [RULE3] timer high-byte write decrements, sticks at 00
// [RULE4] alarm high-byte write decrements, sticks at 00
// [RULE5] any alarm window read decrements pointer
// [RULE6] any timer window read decrements pointer
// [RULE7] low-byte writes never move pointers
// [RULE8] timer writes need the write-unlock bit
// [RULE9] unlock settable one cycle after 55,aa
// [RULE10] software keeps unlock clear when idle
// [RULE11] locked writes and keyless unlock ignored
package rtcw_pkg;
	// register indices on the address port
	localparam logic [3:0] RTCW_CFG_ADDR = 4'h0;
	localparam logic [3:0] RTCW_ALCFG_ADDR = 4'h1;
	localparam logic [3:0] RTCW_TWIN_ADDR = 4'h2;
	localparam logic [3:0] RTCW_THI_ADDR = 4'h3;
	localparam logic [3:0] RTCW_TLO_ADDR = 4'h4;
	localparam logic [3:0] RTCW_AWIN_ADDR = 4'h5;
	localparam logic [3:0] RTCW_AHI_ADDR = 4'h6;
	localparam logic [3:0] RTCW_ALO_ADDR = 4'h7;
	localparam logic [3:0] RTCW_KEY_ADDR = 4'h8;
	// field positions
	localparam int RTCW_PTR_LSB = 8;
	localparam int RTCW_UNLOCK_BIT = 13;
	// key values
	localparam logic [7:0] RTCW_KEY_FIRST = 8'h55;
	localparam logic [7:0] RTCW_KEY_SECOND = 8'haa;
	// reset values
	localparam logic [1:0] RTCW_PTR_RST = 2'h0;
	localparam logic [7:0] RTCW_BYTE_RST = 8'h00;
	localparam logic [15:0] RTCW_WORD_RST = 16'h0000;
	// byte slots of the timer store: sec, min, hr, wday, day, month, year
	localparam int RTCW_TBYTES = 7;
	localparam int RTCW_ABYTES = 6;
	// unlock key sequencer states, gray along the path
	typedef enum logic [1:0] {
		RTCW_KEY_IDLE = 2'h0,
		RTCW_KEY_GOT1 = 2'h1,
		RTCW_KEY_ARMED = 2'h3
	} rtcw_key_state_t;
endpackage : rtcw_pkg

/* rtl/rtcw_ptr_if.sv */
// carrier between the top and one window pointer
// assumes a single clock domain
`timescale 1ns/1ps
interface rtcw_ptr_if;
	logic load;
	logic [1:0] loadVal;
	logic decr;
	logic [1:0] ptr;
	modport ctrl (output load, output loadVal, output decr, input ptr);
	modport unit (input load, input loadVal, input decr, output ptr);
endinterface : rtcw_ptr_if

/* rtl/rtcw_ptr_unit.sv */
// two-bit window pointer with load and saturating decrement
// assumes load and decr are single-cycle terms from mclk logic
`timescale 1ns/1ps
module rtcw_ptr_unit (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// pointer carrier
	rtcw_ptr_if.unit p
);
	import rtcw_pkg::*;
	typedef struct packed {
		logic [1:0] ptr;
	} rtcw_ptr_state_t;
	rtcw_ptr_state_t st;
	rtcw_ptr_state_t next_st;
	// software load wins, else decrement down to 00 and hold
	always_comb begin
		next_st = st;
		if (p.load) begin
			next_st.ptr = p.loadVal;
		// [RULE3] [RULE4] saturating decrement
		end else if (p.decr && st.ptr != 2'h0) begin
			next_st.ptr = st.ptr - 2'h1;
		end
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			st.ptr <= RTCW_PTR_RST;
		end else begin
			st <= next_st;
		end
	end
	assign p.ptr = st.ptr;
endmodule : rtcw_ptr_unit

/* rtl/rtcw_key_seq.sv */
// unlock key sequencer: opens a one-cycle window after 55 then aa
// assumes write strobes from the register port on mclk
`timescale 1ns/1ps
module rtcw_key_seq (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// register writes
	input wire logic anyWr,
	input wire logic keyWr,
	input wire logic [7:0] keyData,
	// unlock window open
	output logic armed
);
	import rtcw_pkg::*;
	typedef struct packed {
		rtcw_key_state_t state;
	} rtcw_key_reg_t;
	rtcw_key_reg_t st;
	rtcw_key_reg_t next_st;
	// any write other than the aa key or a repeated 55 key between the two keys breaks the sequence
	always_comb begin
		next_st = st;
		unique case (st.state)
			RTCW_KEY_IDLE: begin
				if (keyWr && keyData == RTCW_KEY_FIRST) begin
					next_st.state = RTCW_KEY_GOT1;
				end
			end
			RTCW_KEY_GOT1: begin
				// [RULE9] second key arms
				if (keyWr && keyData == RTCW_KEY_SECOND) begin
					next_st.state = RTCW_KEY_ARMED;
				end else if (keyWr && keyData == RTCW_KEY_FIRST) begin
					next_st.state = RTCW_KEY_GOT1;
				end else if (anyWr) begin
					next_st.state = RTCW_KEY_IDLE;
				end
			end
			RTCW_KEY_ARMED: begin
				// [RULE9] window lasts one cycle
				if (keyWr && keyData == RTCW_KEY_FIRST) begin
					next_st.state = RTCW_KEY_GOT1;
				end else begin
					next_st.state = RTCW_KEY_IDLE;
				end
			end
			default: begin
				next_st.state = RTCW_KEY_IDLE;
			end
		endcase
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			st.state <= RTCW_KEY_IDLE;
		end else begin
			st <= next_st;
		end
	end
	assign armed = (st.state == RTCW_KEY_ARMED);
endmodule : rtcw_key_seq

/* rtl/rtcw_window_lock.sv */
// register front end: timer and alarm windows, pointers, write lock
// assumes a single-cycle strobe register port; read data one cycle later
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module rtcw_window_lock (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [15:0] rdData,
	// status
	output logic timerWriteUnlock,
	output logic [1:0] timerWindowPointer,
	output logic [1:0] alarmWindowPointer
);
	import rtcw_pkg::*;
	typedef struct packed {
		logic [RTCW_TBYTES-1:0][7:0] tval;
		logic [RTCW_ABYTES-1:0][7:0] aval;
		logic cfgEnable;
		logic [7:0] cfgCal;
		logic alEnable;
		logic [7:0] alRepeat;
		logic unlock;
		logic [15:0] rdData;
	} rtcw_state_t;
	rtcw_state_t st;
	rtcw_state_t next_st;
	rtcw_ptr_if tPtr ();
	rtcw_ptr_if aPtr ();
	logic armed;
	logic keyWr;
	logic tWinWr;
	logic tHiWr;
	logic tLoWr;
	logic tRd;
	logic aWinWr;
	logic aHiWr;
	logic aLoWr;
	logic aRd;
	logic [15:0] tView;
	logic [15:0] aView;
	logic [15:0] cfgView;
	logic [15:0] alcfgView;

	// key sequencer
	rtcw_key_seq keySeq (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.anyWr(wrStb),
		.keyWr(keyWr),
		.keyData(wrData[7:0]),
		.armed(armed)
	);
	// timer pointer
	rtcw_ptr_unit timerPtrUnit (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.p(tPtr)
	);
	// alarm pointer
	rtcw_ptr_unit alarmPtrUnit (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.p(aPtr)
	);

	// address decode of the strobes
	assign keyWr = wrStb && addr == RTCW_KEY_ADDR;
	// [RULE8] [RULE11] locked timer writes dropped
	assign tWinWr = wrStb && st.unlock && addr == RTCW_TWIN_ADDR;
	assign tHiWr = wrStb && st.unlock && addr == RTCW_THI_ADDR;
	assign tLoWr = wrStb && st.unlock && addr == RTCW_TLO_ADDR;
	assign aWinWr = wrStb && addr == RTCW_AWIN_ADDR;
	assign aHiWr = wrStb && addr == RTCW_AHI_ADDR;
	assign aLoWr = wrStb && addr == RTCW_ALO_ADDR;
	assign tRd = rdStb && (addr == RTCW_TWIN_ADDR || addr == RTCW_THI_ADDR || addr == RTCW_TLO_ADDR);
	assign aRd = rdStb && (addr == RTCW_AWIN_ADDR || addr == RTCW_AHI_ADDR || addr == RTCW_ALO_ADDR);

	// pointer control: config writes load, window reads and accepted window or high-byte writes decrement
	assign tPtr.load = wrStb && addr == RTCW_CFG_ADDR;
	assign tPtr.loadVal = wrData[RTCW_PTR_LSB+1:RTCW_PTR_LSB];
	// [RULE3] [RULE6] [RULE7] timer pointer steps
	assign tPtr.decr = tWinWr || tHiWr || tRd;
	assign aPtr.load = wrStb && addr == RTCW_ALCFG_ADDR;
	assign aPtr.loadVal = wrData[RTCW_PTR_LSB+1:RTCW_PTR_LSB];
	// [RULE4] [RULE5] [RULE7] alarm pointer steps
	assign aPtr.decr = aWinWr || aHiWr || aRd;

	// [RULE1] timer pair selection
	always_comb begin
		unique case (tPtr.ptr)
			2'h0: tView = {st.tval[1], st.tval[0]};
			2'h1: tView = {st.tval[3], st.tval[2]};
			2'h2: tView = {st.tval[5], st.tval[4]};
			2'h3: tView = {RTCW_BYTE_RST, st.tval[6]};
		endcase
	end

	// [RULE2] alarm pair selection, 11 shows nothing
	always_comb begin
		unique case (aPtr.ptr)
			2'h0: aView = {st.aval[1], st.aval[0]};
			2'h1: aView = {st.aval[3], st.aval[2]};
			2'h2: aView = {st.aval[5], st.aval[4]};
			2'h3: aView = RTCW_WORD_RST;
		endcase
	end

	// config views with pointer fields in place, unlock field in the timer view only
	always_comb begin
		cfgView = RTCW_WORD_RST;
		cfgView[15] = st.cfgEnable;
		cfgView[RTCW_UNLOCK_BIT] = st.unlock;
		cfgView[RTCW_PTR_LSB+1:RTCW_PTR_LSB] = tPtr.ptr;
		cfgView[7:0] = st.cfgCal;
		alcfgView = RTCW_WORD_RST;
		alcfgView[15] = st.alEnable;
		alcfgView[RTCW_PTR_LSB+1:RTCW_PTR_LSB] = aPtr.ptr;
		alcfgView[7:0] = st.alRepeat;
	end

	// register file update and read capture
	always_comb begin
		next_st = st;
		next_st.rdData = RTCW_WORD_RST;
		if (rdStb) begin
			unique case (addr)
				RTCW_CFG_ADDR: next_st.rdData = cfgView;
				RTCW_ALCFG_ADDR: next_st.rdData = alcfgView;
				RTCW_TWIN_ADDR: next_st.rdData = tView;
				RTCW_THI_ADDR: next_st.rdData = {RTCW_BYTE_RST, tView[15:8]};
				RTCW_TLO_ADDR: next_st.rdData = {RTCW_BYTE_RST, tView[7:0]};
				RTCW_AWIN_ADDR: next_st.rdData = aView;
				RTCW_AHI_ADDR: next_st.rdData = {RTCW_BYTE_RST, aView[15:8]};
				RTCW_ALO_ADDR: next_st.rdData = {RTCW_BYTE_RST, aView[7:0]};
				default: next_st.rdData = RTCW_WORD_RST;
			endcase
		end
		if (wrStb && addr == RTCW_CFG_ADDR) begin
			next_st.cfgEnable = wrData[15];
			next_st.cfgCal = wrData[7:0];
			// [RULE9] [RULE11] set only while armed
			if (!wrData[RTCW_UNLOCK_BIT]) begin
				next_st.unlock = 1'b0;
			end else if (armed) begin
				next_st.unlock = 1'b1;
			end
		end
		if (wrStb && addr == RTCW_ALCFG_ADDR) begin
			next_st.alEnable = wrData[15];
			next_st.alRepeat = wrData[7:0];
		end
		// [RULE1] [RULE8] timer window store at current pair
		if (tWinWr || tHiWr) begin
			if (tPtr.ptr != 2'h3) begin
				next_st.tval[{tPtr.ptr, 1'b1}] = tWinWr ? wrData[15:8] : wrData[7:0];
			end
		end
		if (tWinWr || tLoWr) begin
			if (tPtr.ptr == 2'h3) begin
				next_st.tval[6] = wrData[7:0];
			end else begin
				next_st.tval[{tPtr.ptr, 1'b0}] = wrData[7:0];
			end
		end
		// [RULE2] alarm window store, pair 11 holds nothing
		if ((aWinWr || aHiWr) && aPtr.ptr != 2'h3) begin
			next_st.aval[{aPtr.ptr, 1'b1}] = aWinWr ? wrData[15:8] : wrData[7:0];
		end
		if ((aWinWr || aLoWr) && aPtr.ptr != 2'h3) begin
			next_st.aval[{aPtr.ptr, 1'b0}] = wrData[7:0];
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// outputs
	assign rdData = st.rdData;
	assign timerWriteUnlock = st.unlock;
	assign timerWindowPointer = tPtr.ptr;
	assign alarmWindowPointer = aPtr.ptr;
endmodule : rtcw_window_lock

/* test/rtcw_asserts.sv */
// port checker of the window access block
// assumes it is bound onto rtcw_window_lock
`timescale 1ns/1ps
module rtcw_asserts (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	input wire logic [15:0] rdData,
	// status
	input wire logic timerWriteUnlock,
	input wire logic [1:0] timerWindowPointer,
	input wire logic [1:0] alarmWindowPointer
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// window index groups
	wire logic tAcc = addr inside {[4'h2:4'h4]};
	wire logic aAcc = addr inside {[4'h5:4'h7]};
	wire logic [1:0] tp = timerWindowPointer;
	wire logic [1:0] ap = alarmWindowPointer;
	a_trd_dec: assert property (rdStb && tAcc && tp != 2'h0 |=> tp == $past(tp) - 2'h1)
		else $error("timer read did not step pointer");
	a_ard_dec: assert property (rdStb && aAcc && ap != 2'h0 |=> ap == $past(ap) - 2'h1)
		else $error("alarm read did not step pointer");
	a_thi_dec: assert property (wrStb && addr inside {4'h2, 4'h3} && timerWriteUnlock && tp != 2'h0
		|=> tp == $past(tp) - 2'h1)
		else $error("timer high write did not step pointer");
	a_ahi_dec: assert property (wrStb && addr inside {4'h5, 4'h6} && ap != 2'h0 |=> ap == $past(ap) - 2'h1)
		else $error("alarm high write did not step pointer");
	a_zero_stick: assert property ((wrStb || rdStb) && addr != 4'h0 && tp == 2'h0 |=> tp == 2'h0)
		else $error("timer pointer left zero");
	a_lo_keep: assert property (wrStb && addr inside {4'h4, 4'h7} |=> $stable(tp) && $stable(ap))
		else $error("low byte write moved a pointer");
	a_lock_drop: assert property (wrStb && tAcc && !timerWriteUnlock |=> $stable(tp))
		else $error("locked timer write moved pointer");
	a_unlock_key: assert property ($rose(timerWriteUnlock) |-> $past(wrStb) && $past(addr) == 4'h0
		&& $past(wrStb, 2) && $past(addr, 2) == 4'h8 && $past(wrData[7:0], 2) == 8'haa)
		else $error("unlock set without key");
endmodule : rtcw_asserts
bind rtcw_window_lock rtcw_asserts u_chk (.mclk, .sys_rst, .addr, .wrData, .wrStb, .rdStb, .rdData,
	.timerWriteUnlock, .timerWindowPointer, .alarmWindowPointer);

/* test/rtcw_window_lock_tb_top.sv */
// directed bench of the window access block
// assumes 40 MHz mclk and the one-cycle strobe register port
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
	$display("wrong value at %0t: got %h want %h", $time, g, e); end end
module rtcw_window_lock_tb_top;
	import rtcw_pkg::*;
	logic mclk, sys_rst, wrStb, rdStb, unlock;
	logic [3:0] addr;
	logic [15:0] wrData, rdData;
	logic [1:0] tPtr, aPtr;
	int errors = 0;
	int n_tests = 0;
	rtcw_window_lock DUT (.mclk(mclk), .sys_rst(sys_rst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
		.rdStb(rdStb), .rdData(rdData), .timerWriteUnlock(unlock), .timerWindowPointer(tPtr),
		.alarmWindowPointer(aPtr));
	// clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// one port cycle, taken at the next edge
	task op(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
		wrStb <= w;
		rdStb <= r;
		addr <= a;
		wrData <= d;
		@(posedge mclk);
		#1;
	endtask : op
	task wr(input logic [3:0] a, input logic [15:0] d);
		op(1'b1, 1'b0, a, d);
	endtask : wr
	task rd(input logic [3:0] a, input logic [15:0] e);
		op(1'b0, 1'b1, a, 16'h0000);
		`CHK(rdData, e)
	endtask : rd
	// key sequence and its window
	task unlock_seq;
		wr(4'h0, 16'h2000);
		`CHK(unlock, 1'h0)
		wr(4'h8, 16'h0055);
		wr(4'h8, 16'h00aa);
		op(1'b0, 1'b0, 4'h0, 16'h0000);
		wr(4'h0, 16'h2000);
		`CHK(unlock, 1'h0)
		wr(4'h8, 16'h0055);
		wr(4'h8, 16'h00aa);
		wr(4'h0, 16'h2300);
		`CHK(unlock, 1'h1)
	endtask : unlock_seq
	// timer fill by writes, then read back
	task timer_seq;
		wr(4'h2, 16'h0019);
		`CHK(tPtr, 2'h2)
		wr(4'h2, 16'h0c1f);
		wr(4'h4, 16'h0077);
		`CHK(tPtr, 2'h1)
		wr(4'h3, 16'h0003);
		wr(4'h2, 16'h2d3a);
		wr(4'h3, 16'h002e);
		`CHK(tPtr, 2'h0)
		wr(4'h0, 16'h2300);
		rd(4'h2, 16'h0019);
		rd(4'h4, 16'h001f);
		rd(4'h3, 16'h0003);
		rd(4'h2, 16'h2e3a);
	endtask : timer_seq
	// locked timer writes are dropped
	task lock_seq;
		wr(4'h0, 16'h0300);
		`CHK(unlock, 1'h0)
		wr(4'h2, 16'hffff);
		wr(4'h3, 16'h00ff);
		`CHK(tPtr, 2'h3)
		rd(4'h2, 16'h0019);
	endtask : lock_seq
	// alarm pointer walk
	task alarm_seq;
		wr(4'h1, 16'h0300);
		wr(4'h5, 16'h1234);
		wr(4'h5, 16'h0a1b);
		wr(4'h7, 16'h0009);
		`CHK(aPtr, 2'h1)
		wr(4'h6, 16'h0004);
		wr(4'h5, 16'h5958);
		`CHK(aPtr, 2'h0)
		wr(4'h1, 16'h0300);
		rd(4'h5, 16'h0000);
		rd(4'h7, 16'h001b);
		rd(4'h6, 16'h0004);
		rd(4'h5, 16'h5958);
		rd(4'hf, 16'h0000);
	endtask : alarm_seq
	task end_of_test;
		$display("errors %0d checks %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	// watchdog
	initial begin
		#20000;
		errors++;
		end_of_test();
	end
	// main sequence
	initial begin
		sys_rst = 1'b1;
		wrStb = 1'b0;
		rdStb = 1'b0;
		addr = 4'h0;
		wrData = 16'h0000;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		op(1'b0, 1'b0, 4'h0, 16'h0000);
		`CHK({unlock, tPtr, aPtr, rdData}, 21'h0)
		unlock_seq();
		timer_seq();
		lock_seq();
		alarm_seq();
		op(1'b0, 1'b0, 4'h0, 16'h0000);
		end_of_test();
	end
endmodule : rtcw_window_lock_tb_top
